// >>> rtl/rbs_pkg.sv
package rbs_pkg;
  localparam int CLK_MHZ            = 40;
  localparam int BUSY_MAX_MS        = 75;
  localparam int BUSY_MAX_CYC       = BUSY_MAX_MS * CLK_MHZ * 1000;
  localparam int RST_MIN_NS         = 50;
  localparam int CLK_NS             = 25;
  localparam int RST_MIN_CYC        = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int AVD_SETUP_US       = 3;
  localparam int AVD_SETUP_CYC      = AVD_SETUP_US * CLK_MHZ;
  localparam int BOOT_ADDR_W        = 10;
  localparam int BOOT_DATA_W        = 16;
  localparam int BOOT_WORDS         = 1024;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PAGED  = 2'h1;
  typedef enum logic [1:0] {
    RBS_IDLE,
    RBS_COPY,
    RBS_READY
  } rbs_state_t;
endpackage

// >>> rtl/rbs_boot_ram.sv
`timescale 1ns/1ps
`default_nettype none
module rbs_boot_ram #(
  parameter int AW = 10,
  parameter int DW = 16
) (
  // clock
  input  wire logic          i_core_clk,
  // write port
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  // read port
  input  wire logic [AW-1:0] i_raddr,
  output logic      [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [2**AW];
  always_ff @(posedge i_core_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end
  always_ff @(posedge i_core_clk) begin
    o_rdata <= mem[i_raddr];
  end
endmodule
`default_nettype wire

// >>> rtl/rbs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module rbs_sequencer
  import rbs_pkg::*;
#(
  parameter int BUSY_LIMIT = BUSY_MAX_CYC,
  parameter int WORDS      = BOOT_WORDS
) (
  // clock and reset
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rst_b,
  // boot load mode pins
  input  wire logic [1:0]             i_boot_load_mode,
  // flash source
  output logic                        o_flash_req,
  output logic [BOOT_ADDR_W-1:0]      o_flash_addr,
  input  wire logic                   i_flash_valid,
  input  wire logic [BOOT_DATA_W-1:0] i_flash_data,
  // host port, active-low strobes from pins
  input  wire logic                   i_chip_en_b,
  input  wire logic                   i_out_en_b,
  input  wire logic [BOOT_ADDR_W-1:0] i_host_addr,
  output logic [BOOT_DATA_W-1:0]      o_host_rdata,
  output logic                        o_host_rvalid,
  // status
  output logic                        o_busy_b,
  output logic                        o_timeout
);
  rbs_state_t                 state;
  logic [1:0]                 ce_sync;
  logic [1:0]                 oe_sync;
  logic [BOOT_ADDR_W:0]       copy_cnt;
  logic [31:0]                busy_cnt;
  logic [1:0]                 mode;
  logic                       ram_we;
  logic [BOOT_DATA_W-1:0]     ram_rdata;
  logic                       rd_pend;
  logic                       copy_done;
  logic [1:0]                 mode_s0;
  logic [1:0]                 mode_s1;
  logic [BOOT_ADDR_W-1:0]     addr_s0;
  logic [BOOT_ADDR_W-1:0]     addr_s1;

  // straps and address are pins; no reset so they settle while reset is held
  always_ff @(posedge i_core_clk) begin
    mode_s0 <= i_boot_load_mode;
    mode_s1 <= mode_s0;
    addr_s0 <= i_host_addr;
    addr_s1 <= addr_s0;
  end

  // pins cross two flops before use
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ce_sync <= 2'h3;
      oe_sync <= 2'h3;
    end else begin
      ce_sync <= {ce_sync[0], i_chip_en_b};
      oe_sync <= {oe_sync[0], i_out_en_b};
    end
  end

  // mode strap caught after release
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode <= MODE_NORMAL;
    end else if (state == RBS_IDLE) begin
      mode <= mode_s1;
    end
  end

  assign copy_done = (copy_cnt == (BOOT_ADDR_W+1)'(WORDS - 1)) && i_flash_valid;

  // async reset holds all but the strap/address flops and boot RAM idle
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= RBS_IDLE;
    end else begin
      case (state)
        RBS_IDLE:  state <= RBS_COPY;
        RBS_COPY:  if (copy_done || busy_cnt == 32'(BUSY_LIMIT - 2)) state <= RBS_READY;
        RBS_READY: state <= RBS_READY;
        default:   state <= RBS_IDLE;
      endcase
    end
  end

  // flash fetch walks the boot window
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      copy_cnt     <= '0;
      o_flash_req  <= 1'b0;
      o_flash_addr <= '0;
    end else begin
      o_flash_req <= (state == RBS_COPY) && !copy_done;
      if (state == RBS_COPY && i_flash_valid && !copy_done) begin
        copy_cnt <= copy_cnt + 1'b1;
      end
      o_flash_addr <= copy_cnt[BOOT_ADDR_W-1:0] + ((state == RBS_COPY && i_flash_valid) ? 1'b1 : 1'b0);
    end
  end

  assign ram_we = (state == RBS_COPY) && i_flash_valid;

  // paged mode is only recorded; the copy length is the same
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy_cnt  <= '0;
      o_timeout <= 1'b0;
    end else if (state == RBS_COPY) begin
      busy_cnt <= busy_cnt + 32'h1;
      if (busy_cnt == 32'(BUSY_LIMIT - 2) && !copy_done) begin
        o_timeout <= 1'b1;
      end
    end
  end

  // busy low from reset until the copy ends
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_busy_b <= 1'b0;
    end else begin
      o_busy_b <= (state == RBS_READY);
    end
  end

  rbs_boot_ram #(
    .AW(BOOT_ADDR_W),
    .DW(BOOT_DATA_W)
  ) u_ram (
    .i_core_clk (i_core_clk),
    .i_we       (ram_we),
    .i_waddr    (copy_cnt[BOOT_ADDR_W-1:0]),
    .i_wdata    (i_flash_data),
    .i_raddr    (addr_s1),
    .o_rdata    (ram_rdata)
  );

  // host reads answered only once ready; during copy they are dropped
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_pend       <= 1'b0;
      o_host_rvalid <= 1'b0;
      o_host_rdata  <= '0;
    end else begin
      rd_pend       <= (state == RBS_READY) && !ce_sync[1] && !oe_sync[1];
      o_host_rvalid <= rd_pend && (state == RBS_READY);
      o_host_rdata  <= rd_pend ? ram_rdata : '0;
    end
  end

  a_busy_in_copy: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (state != RBS_READY) |=> !o_busy_b) else $error("busy released before copy end");

  a_no_ans_copy: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (state == RBS_COPY) |-> ##1 !o_host_rvalid) else $error("answer during copy");

  a_copy_starts: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    $rose(i_rst_b) ##0 (state == RBS_IDLE) |=> (state == RBS_COPY)) else $error("copy did not start");

  a_busy_bound: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (state == RBS_COPY) |-> busy_cnt < 32'(BUSY_LIMIT)) else $error("busy exceeds limit");

  a_ready_stays: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_busy_b |=> o_busy_b) else $error("busy reasserted without reset");

  // sequencing checks on the design's own state
  a_busy_on_reset: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    $rose(i_rst_b) |-> !o_busy_b) else $error("busy not held at release");

  a_flash_idle_rst: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    $rose(i_rst_b) |-> !o_flash_req) else $error("fetch active at release");

  a_copy_ends_ready: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (state == RBS_COPY && copy_done) |=> (state == RBS_READY)) else $error("copy end missed");

  a_ready_releases: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (state == RBS_READY) |=> o_busy_b) else $error("busy held after copy");

  a_limit_flag: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (state == RBS_COPY && busy_cnt == 32'(BUSY_LIMIT - 2) && !copy_done) |=> o_timeout)
    else $error("limit not flagged");

  a_no_fetch_ready: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (state == RBS_READY) |=> !o_flash_req) else $error("fetch after copy");

  a_req_in_copy: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_flash_req |-> (state != RBS_IDLE)) else $error("fetch while idle");

  a_answer_ready: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_host_rvalid |-> o_busy_b) else $error("answer while busy");

  a_rdata_zero: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    !rd_pend |=> (o_host_rdata == '0)) else $error("stale read data");

  a_wait_no_read: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (state != RBS_READY) |=> !rd_pend) else $error("read taken while busy");

  a_timeout_sticky: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_timeout |=> o_timeout) else $error("limit flag dropped");

  a_copy_count: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (state == RBS_COPY && i_flash_valid && !copy_done) |=> (copy_cnt == $past(copy_cnt) + 1'b1))
    else $error("copy count skipped");

  a_mode_held: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (state != RBS_IDLE) |=> $stable(mode)) else $error("mode changed after start");
endmodule
`default_nettype wire

// >>> testbench/rbs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rbs_host_model
  import rbs_pkg::*;
(
  // clock and status
  input  wire logic                   i_core_clk,
  input  wire logic                   i_busy_b,
  // read answer
  input  wire logic                   i_rvalid,
  input  wire logic [BOOT_DATA_W-1:0] i_rdata,
  // strobes
  output logic                        o_chip_en_b,
  output logic                        o_out_en_b,
  output logic [BOOT_ADDR_W-1:0]      o_addr
);
  // no address strobe is raised; strobes idle high from the start
  initial begin
    o_chip_en_b = 1'b1;
    o_out_en_b  = 1'b1;
    o_addr      = '0;
  end
  // strobes stay high while polling
  task automatic wait_ready(output logic ok);
    ok = 1'b0;
    for (int n = 0; n < 2100 && !ok; n++) begin
      @(posedge i_core_clk);
      ok = (i_busy_b === 1'b1);
    end
  endtask
  task automatic read(input logic [BOOT_ADDR_W-1:0] a, output logic [BOOT_DATA_W-1:0] d, output logic ok);
    o_chip_en_b <= 1'b0;
    o_out_en_b  <= 1'b0;
    o_addr      <= a;
    ok = 1'b0;
    for (int n = 0; n < 8 && !ok; n++) begin
      @(posedge i_core_clk);
      ok = (i_rvalid === 1'b1);
      d  = i_rdata;
    end
    o_chip_en_b <= 1'b1;
    o_out_en_b  <= 1'b1;
    o_addr      <= ~a;
    // let the answer tail drain
    repeat (6) @(posedge i_core_clk);
  endtask
endmodule
`default_nettype wire

// >>> testbench/rbs_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
module rbs_sequencer_test
  import rbs_pkg::*;
;
  localparam int LIMIT = 2000;
  logic                   clk, rst_b, fvalid, fon, ce_b, oe_b, freq, rvalid, busy_b, tmo, ok;
  logic [1:0]             mode;
  logic [BOOT_ADDR_W-1:0] faddr, haddr;
  logic [BOOT_DATA_W-1:0] fdata, rdata, d;
  int                     n_fail, checks_done, cyc, t0;
  rbs_sequencer #(.BUSY_LIMIT(LIMIT), .WORDS(8)) i_rbs_sequencer (.i_core_clk(clk), .i_rst_b(rst_b),
    .i_boot_load_mode(mode), .o_flash_req(freq), .o_flash_addr(faddr), .i_flash_valid(fvalid),
    .i_flash_data(fdata), .i_chip_en_b(ce_b), .i_out_en_b(oe_b), .i_host_addr(haddr),
    .o_host_rdata(rdata), .o_host_rvalid(rvalid), .o_busy_b(busy_b), .o_timeout(tmo));
  rbs_host_model i_rbs_host_model (.i_core_clk(clk), .i_busy_b(busy_b), .i_rvalid(rvalid),
    .i_rdata(rdata), .o_chip_en_b(ce_b), .o_out_en_b(oe_b), .o_addr(haddr));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // flash answers every other cycle only, a slow source
  always @(posedge clk) begin
    cyc    <= cyc + 1;
    fvalid <= fon && freq && !fvalid;
    fdata  <= 16'h5A00 ^ 16'(faddr);
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic chk(input logic [BOOT_DATA_W-1:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic do_reset(input logic [1:0] m);
    rst_b <= 1'b0;
    mode  <= m;
    repeat (2) @(posedge clk);
    chk(busy_b, 1'b0);
    chk(rvalid, 1'b0);
    rst_b <= 1'b1;
    t0 = cyc;
    @(posedge clk);
  endtask
  task automatic t_boot(input logic [1:0] m);
    fon <= 1'b0;
    do_reset(m);
    i_rbs_host_model.read(10'h3, d, ok);
    chk(ok, 1'b0);
    chk(busy_b, 1'b0);
    fon <= 1'b1;
    i_rbs_host_model.wait_ready(ok);
    chk(ok, 1'b1);
    chk(tmo, 1'b0);
    for (int a = 0; a < 8; a++) begin
      i_rbs_host_model.read(a[BOOT_ADDR_W-1:0], d, ok);
      chk(ok, 1'b1);
      chk(d, 16'h5A00 ^ 16'(a));
    end
  endtask
  task automatic t_limit();
    fon <= 1'b0;
    do_reset(MODE_NORMAL);
    i_rbs_host_model.wait_ready(ok);
    chk(ok && (cyc - t0 <= LIMIT + 4), 1'b1);
    chk(tmo, 1'b1);
    // boot RAM keeps the earlier boot's words; a read after the limit is answered
    i_rbs_host_model.read(10'h1, d, ok);
    chk(ok, 1'b1);
    chk(d, 16'h5A01);
  endtask
  task automatic final_report();
    if (n_fail == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    rst_b  = 1'b0;
    fon    = 1'b0;
    mode   = MODE_NORMAL;
    repeat (2) @(posedge clk);
    t_boot(MODE_NORMAL);
    t_boot(MODE_PAGED);
    t_limit();
    // a starved copy must not poison the next boot
    t_boot(MODE_NORMAL);
    final_report();
  end
endmodule
`default_nettype wire
